// ==== phb_pkg.sv ====
// Behaviour
// - Eight-bit two-way host data bus
// - Strobes honoured only while chip select low
// - Byte select picks high or low byte
// - Status select chooses output buffer or status
// - Strobe-pair write latches on first rising edge
// - Read/write-line mode: input strobe gives direction
// - Strobe-pair mode: output strobe low drives output buffer
// - Single data strobe with selectable active level
// - Input full set on latch, cleared by read
// - Optional OR of full and empty on pin
// - Output empty set after read, cleared by write
// - Select bit muxes host port or serial pins
// - Select plus upper enable gives eight bit lines
// - Bit lines direction, set, toggle, clear, test
package phb_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          PHB_BUS_W       = 8;
    localparam int          PHB_WORD_W      = 16;
    localparam int          PHB_FIFO_DEPTH  = 16;
    localparam logic        PHB_IN_FULL_RST = 1'b0;
    localparam logic        PHB_OUT_EMPTY_RST = 1'b1;
    localparam logic [15:0] PHB_WORD_RST    = 16'h0000;
    localparam logic [7:0]  PHB_BYTE_RST    = 8'h00;

    // ------------------------------------------------------------
    // Status byte field positions
    // ------------------------------------------------------------
    localparam int PHB_ST_IN_FULL   = 0;
    localparam int PHB_ST_OUT_EMPTY = 1;

    // ------------------------------------------------------------
    // Bit line operation codes
    // ------------------------------------------------------------
    localparam logic [1:0] PHB_BIO_HOLD   = 2'h0;
    localparam logic [1:0] PHB_BIO_SET    = 2'h1;
    localparam logic [1:0] PHB_BIO_CLEAR  = 2'h2;
    localparam logic [1:0] PHB_BIO_TOGGLE = 2'h3;

    // Host access phase
    typedef enum logic [2:0] {
        PHB_IDLE  = 3'b001,
        PHB_WRITE = 3'b010,
        PHB_READ  = 3'b100
    } phb_phase_e;

endpackage

// ==== phb_fifo.sv ====
`timescale 1ns/1ps
module phb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } phbf_s;

    phbf_s st;
    phbf_s next_st;
    logic  push;
    logic  pop;

    // Handshakes; full and empty come from the count
    assign o_ready = (st.cnt < (AW+1)'(DEPTH));
    assign o_valid = (st.cnt != '0);
    assign o_data  = st.mem[st.rd];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    // Pointer and storage update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = i_data;
            next_st.wr         = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // phb_fifo

// ==== phb_host_port.sv ====
`timescale 1ns/1ps
module phb_host_port
    import phb_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESET_N,
    // Host pins
    input  wire logic [7:0]  I_HOST_DATA_BUS,
    output logic [7:0]       O_HOST_DATA_BUS,
    output logic [7:0]       O_HOST_DATA_BUS_OE,
    input  wire logic        I_HOST_CHIP_SELECT_N,
    input  wire logic        I_HOST_BYTE_SELECT,
    input  wire logic        I_HOST_STATUS_SELECT,
    input  wire logic        I_HOST_INPUT_STROBE,
    input  wire logic        I_HOST_OUTPUT_STROBE,
    output logic             O_HOST_IN_FULL_FLAG,
    output logic             O_HOST_OUT_EMPTY_FLAG,
    // Configuration
    input  wire logic        I_RW_LINE_MODE,
    input  wire logic        I_STROBE_ACTIVE_HIGH,
    input  wire logic        I_BYTE_SELECT_HIGH_IS_1,
    input  wire logic        I_WORD_MODE,
    input  wire logic        I_FULL_OR_EMPTY,
    input  wire logic        I_SECOND_SERIAL_SELECT,
    input  wire logic        I_UPPER_BITIO_ENABLE,
    // Processor side
    output logic [15:0]      O_IN_DATA,
    output logic             O_IN_VALID,
    input  wire logic        I_IN_READ,
    input  wire logic [15:0] I_OUT_DATA,
    input  wire logic        I_OUT_WRITE,
    output logic             O_OUT_READY,
    // Second serial port pins
    input  wire logic [3:0]  I_SERIAL_OUT,
    input  wire logic [3:0]  I_SERIAL_OE,
    output logic [3:0]       O_SERIAL_IN,
    // Bit I/O unit
    input  wire logic [7:0]  I_BIT_IO_DIR,
    input  wire logic [1:0]  I_BIT_IO_OP,
    input  wire logic [7:0]  I_BIT_IO_MASK,
    input  wire logic [7:0]  I_BIT_IO_PATTERN,
    input  wire logic [7:0]  I_BIT_IO_LINES,
    output logic [7:0]       O_BIT_IO_LINES,
    output logic [7:0]       O_BIT_IO_LINES_OE,
    output logic             O_BIT_IO_MATCH,
    output logic             O_BIT_IO_ANY
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        phb_phase_e  phase;
        logic        is_hi;
        logic        was_hi;
        logic [7:0]  in_hi;
        logic [15:0] in_word;
        logic        in_full;
        logic [15:0] out_word;
        logic        out_empty;
        logic        push;
        logic [7:0]  dout;
        logic [7:0]  doe;
        logic        full_pin;
        logic        empty_pin;
        logic [15:0] in_data;
        logic        in_valid;
        logic        out_ready;
        logic [3:0]  ser_in;
        logic [7:0]  bio_out;
        logic [7:0]  bio_pin;
        logic [7:0]  bio_oe;
        logic        match;
        logic        any;
    } phb_s;

    phb_s        st;
    phb_s        next_st;
    logic        host_port_on;
    logic        sel;
    logic        wr_act;
    logic        rd_act;
    logic        hi_byte;
    logic        fifo_ready;
    logic [15:0] fifo_data;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [7:0]  status_byte;
    logic [7:0]  out_byte;
    logic        pb_lo_host;
    logic        pb_hi_host;
    logic [7:0]  bio_in;

    // ------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------
    // Host port owns the pins unless the serial port is selected
    assign host_port_on = !I_SECOND_SERIAL_SELECT;
    assign pb_lo_host   = host_port_on;
    assign pb_hi_host   = host_port_on || !I_UPPER_BITIO_ENABLE;
    // Strobes only seen while chip select is low
    assign sel = host_port_on && !I_HOST_CHIP_SELECT_N;
    // Protocol decode of the two strobes
    always_comb begin
        if (I_RW_LINE_MODE) begin
            wr_act = sel && (I_HOST_OUTPUT_STROBE == I_STROBE_ACTIVE_HIGH)
                     && !I_HOST_INPUT_STROBE;
            rd_act = sel && (I_HOST_OUTPUT_STROBE == I_STROBE_ACTIVE_HIGH)
                     && I_HOST_INPUT_STROBE;
        end else begin
            wr_act = sel && !I_HOST_INPUT_STROBE;
            rd_act = sel && !I_HOST_OUTPUT_STROBE;
        end
    end
    // Byte select polarity is configurable
    assign hi_byte = I_WORD_MODE && (I_HOST_BYTE_SELECT == I_BYTE_SELECT_HIGH_IS_1);

    // Status byte and read data
    always_comb begin
        status_byte                   = PHB_BYTE_RST;
        status_byte[PHB_ST_IN_FULL]   = st.in_full;
        status_byte[PHB_ST_OUT_EMPTY] = st.out_empty;
        if (I_HOST_STATUS_SELECT) begin
            out_byte = status_byte;
        end else if (hi_byte) begin
            out_byte = st.out_word[15:8];
        end else begin
            out_byte = st.out_word[7:0];
        end
    end

    // Words from the host pass through the FIFO to the processor
    assign fifo_pop = I_IN_READ && fifo_valid;
    assign bio_in   = I_BIT_IO_LINES;

    phb_fifo #(
        .WIDTH (PHB_WORD_W),
        .DEPTH (PHB_FIFO_DEPTH)
    ) u_fifo (
        .i_clk     (I_REF_CLK),
        .i_reset_n (I_RESET_N),
        .i_data    (st.in_word),
        .i_valid   (st.push),
        .o_ready   (fifo_ready),
        .o_data    (fifo_data),
        .o_valid   (fifo_valid),
        .i_ready   (I_IN_READ)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // FIFO accepts the latched word, then the input buffer is free
        if (st.push && fifo_ready) begin
            next_st.push    = 1'b0;
        end
        // Input full falls on processor read; host latch wins below
        if (fifo_pop) begin
            next_st.in_full = fifo_valid && (st.push || 1'b0);
        end
        unique case (st.phase)
            PHB_IDLE: begin
                next_st.is_hi = hi_byte;
                if (wr_act) begin
                    next_st.phase = PHB_WRITE;
                end else if (rd_act) begin
                    next_st.phase = PHB_READ;
                end
            end
            PHB_WRITE: begin
                next_st.is_hi = hi_byte;
                // Strobe or chip select going inactive ends the write
                if (!wr_act) begin
                    next_st.phase = PHB_IDLE;
                    if (st.is_hi) begin
                        next_st.in_hi = I_HOST_DATA_BUS;
                    end else if (!st.push || fifo_ready) begin
                        next_st.in_word = I_WORD_MODE ? {st.in_hi, I_HOST_DATA_BUS}
                                                      : {PHB_BYTE_RST, I_HOST_DATA_BUS};
                        next_st.push    = 1'b1;
                        next_st.in_full = 1'b1;
                    end
                end
            end
            PHB_READ: begin
                next_st.is_hi = hi_byte;
                // Strobe or chip select going inactive ends the read
                if (!rd_act) begin
                    next_st.phase = PHB_IDLE;
                    if (!I_HOST_STATUS_SELECT && !st.is_hi) begin
                        next_st.out_empty = 1'b1;
                    end
                end
            end
        endcase
        // Processor write fills the output buffer
        if (I_OUT_WRITE && st.out_empty) begin
            next_st.out_word  = I_OUT_DATA;
            if (!(st.phase == PHB_READ && !rd_act && !st.is_hi)) begin
                next_st.out_empty = 1'b0;
            end
        end
        // Registered pin outputs
        next_st.dout      = out_byte;
        next_st.doe[3:0]  = (pb_lo_host && rd_act) ? 4'hF : I_SERIAL_OE & {4{!pb_lo_host}};
        next_st.doe[7:4]  = (pb_lo_host && rd_act) ? 4'hF
                          : (pb_hi_host ? 4'h0 : st.bio_oe[3:0]);
        if (!pb_lo_host) begin
            next_st.dout[3:0] = I_SERIAL_OUT;
        end
        if (!pb_hi_host) begin
            next_st.dout[7:4] = st.bio_out[3:0];
        end
        next_st.ser_in    = pb_lo_host ? 4'h0 : I_HOST_DATA_BUS[3:0];
        next_st.full_pin  = I_FULL_OR_EMPTY ? (next_st.in_full || next_st.out_empty)
                                            : next_st.in_full;
        next_st.empty_pin = next_st.out_empty;
        next_st.in_data   = fifo_data;
        next_st.in_valid  = fifo_valid && !fifo_pop;
        next_st.out_ready = next_st.out_empty;
        // Bit lines: set, clear or toggle under mask
        unique case (I_BIT_IO_OP)
            PHB_BIO_SET:    next_st.bio_out = st.bio_out | I_BIT_IO_MASK;
            PHB_BIO_CLEAR:  next_st.bio_out = st.bio_out & ~I_BIT_IO_MASK;
            PHB_BIO_TOGGLE: next_st.bio_out = st.bio_out ^ I_BIT_IO_MASK;
            default:        next_st.bio_out = st.bio_out;
        endcase
        next_st.bio_oe  = I_BIT_IO_DIR;
        if (!pb_hi_host) begin
            next_st.bio_pin = next_st.bio_out;
        end else begin
            next_st.bio_pin = {next_st.bio_out[7:4], 4'h0};
        end
        // Pattern tests on inputs
        next_st.match = ((bio_in ^ I_BIT_IO_PATTERN) & I_BIT_IO_MASK & ~I_BIT_IO_DIR)
                        == 8'h00;
        next_st.any   = |(~(bio_in ^ I_BIT_IO_PATTERN) & I_BIT_IO_MASK & ~I_BIT_IO_DIR);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st           <= '0;
            st.phase     <= PHB_IDLE;
            st.in_full   <= PHB_IN_FULL_RST;
            st.out_empty <= PHB_OUT_EMPTY_RST;
            st.empty_pin <= PHB_OUT_EMPTY_RST;
            st.out_ready <= PHB_OUT_EMPTY_RST;
            st.out_word  <= PHB_WORD_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign O_HOST_DATA_BUS       = st.dout;
    assign O_HOST_DATA_BUS_OE    = st.doe;
    assign O_HOST_IN_FULL_FLAG   = st.full_pin;
    assign O_HOST_OUT_EMPTY_FLAG = st.empty_pin;
    assign O_IN_DATA             = st.in_data;
    assign O_IN_VALID            = st.in_valid;
    assign O_OUT_READY           = st.out_ready;
    assign O_SERIAL_IN           = st.ser_in;
    assign O_BIT_IO_LINES        = st.bio_pin;
    assign O_BIT_IO_LINES_OE     = st.bio_oe;
    assign O_BIT_IO_MATCH        = st.match;
    assign O_BIT_IO_ANY          = st.any;

endmodule // phb_host_port

// ==== phb_host_port_props.sv ====
`timescale 1ns/1ps
module phb_host_port_props
    import phb_pkg::*;
(
    input wire logic       I_REF_CLK,
    input wire logic       I_RESET_N,
    input wire logic       I_HOST_CHIP_SELECT_N,
    input wire logic       I_HOST_STATUS_SELECT,
    input wire logic       I_HOST_OUTPUT_STROBE,
    input wire logic       I_RW_LINE_MODE,
    input wire logic       I_FULL_OR_EMPTY,
    input wire logic       I_SECOND_SERIAL_SELECT,
    input wire logic       I_UPPER_BITIO_ENABLE,
    input wire logic       I_OUT_WRITE,
    input wire logic [1:0] I_BIT_IO_OP,
    input wire logic [7:0] I_BIT_IO_MASK,
    input wire logic [7:0] O_HOST_DATA_BUS,
    input wire logic [7:0] O_HOST_DATA_BUS_OE,
    input wire logic       O_HOST_IN_FULL_FLAG,
    input wire logic       O_HOST_OUT_EMPTY_FLAG,
    input wire logic       O_OUT_READY,
    input wire logic [7:0] O_BIT_IO_LINES
);
    // ------------------------------------------------------------
    // Host port and bit line checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);

    // Qualified read cycles in strobe-pair mode
    wire hp_rd = !I_HOST_CHIP_SELECT_N && !I_HOST_OUTPUT_STROBE && !I_RW_LINE_MODE
                 && !I_SECOND_SERIAL_SELECT;
    wire bit_own = I_SECOND_SERIAL_SELECT && I_UPPER_BITIO_ENABLE;

    rst_state_a: assert property ($rose(I_RESET_N) |-> O_HOST_OUT_EMPTY_FLAG
        && O_HOST_DATA_BUS_OE == 8'h00) else $error("reset state wrong");
    idle_undriven_a: assert property ((I_HOST_CHIP_SELECT_N && !I_SECOND_SERIAL_SELECT)[*3]
        |-> O_HOST_DATA_BUS_OE == 8'h00) else $error("bus driven while deselected");
    read_drive_a: assert property ((hp_rd && !I_HOST_STATUS_SELECT)[*2]
        |-> O_HOST_DATA_BUS_OE == 8'hFF) else $error("read not driven");
    status_byte_a: assert property ((hp_rd && I_HOST_STATUS_SELECT)[*2]
        |-> O_HOST_DATA_BUS_OE == 8'hFF && O_HOST_DATA_BUS[7:2] == 6'h00
        && O_HOST_DATA_BUS[1] == O_HOST_OUT_EMPTY_FLAG) else $error("status byte wrong");
    empty_clear_a: assert property (I_OUT_WRITE && O_OUT_READY
        |-> ##[1:3] !O_HOST_OUT_EMPTY_FLAG) else $error("empty not cleared");
    or_flag_a: assert property ((I_FULL_OR_EMPTY && O_HOST_OUT_EMPTY_FLAG)[*3]
        |-> O_HOST_IN_FULL_FLAG) else $error("full pin lacks empty term");
    full_needs_cs_a: assert property ($rose(O_HOST_IN_FULL_FLAG) && !I_FULL_OR_EMPTY
        |-> !$past(I_HOST_CHIP_SELECT_N, 2) || !$past(I_HOST_CHIP_SELECT_N, 3)
        || !$past(I_HOST_CHIP_SELECT_N, 4)) else $error("full set without select");
    bit_set_a: assert property (bit_own && I_BIT_IO_OP == PHB_BIO_SET && I_BIT_IO_MASK == 8'hFF
        |-> ##[1:2] O_BIT_IO_LINES == 8'hFF) else $error("bit set failed");
    bit_clear_a: assert property (bit_own && I_BIT_IO_OP == PHB_BIO_CLEAR && I_BIT_IO_MASK == 8'hFF
        |-> ##[1:2] O_BIT_IO_LINES == 8'h00) else $error("bit clear failed");

    // Main scenarios reached
    cover property ($rose(O_HOST_IN_FULL_FLAG));
    cover property ($fell(O_HOST_OUT_EMPTY_FLAG));
    cover property (I_RW_LINE_MODE && !I_HOST_CHIP_SELECT_N);
endmodule // phb_host_port_props

bind phb_host_port phb_host_port_props props_u (.*);

// ==== phb_host_bfm.sv ====
`timescale 1ns/1ps
module phb_host_bfm (
    input  wire logic       i_clk,
    input  wire logic       i_rw_mode,
    input  wire logic       i_act_high,
    input  wire logic [7:0] i_bus,
    output logic            o_cs_n,
    output logic            o_bsel,
    output logic            o_ssel,
    output logic            o_istb,
    output logic            o_ostb,
    output logic [7:0]      o_data
);
    logic wr_on;
    logic ds_on;
    logic dir_rd;

    // ------------------------------------------------------------
    // Host bus model
    // ------------------------------------------------------------
    // Strobe pins follow the access state and the protocol choice
    assign o_istb = i_rw_mode ? dir_rd : !wr_on;
    assign o_ostb = i_rw_mode ? !(ds_on ^ i_act_high) : !ds_on;

    // Idle host: deselected, strobes inactive
    initial begin
        wr_on = 1'b0;
        ds_on = 1'b0;
        dir_rd = 1'b1;
        o_cs_n = 1'b1;
        o_bsel = 1'b0;
        o_ssel = 1'b0;
        o_data = 8'h00;
    end

    // One byte access; strobe goes inactive a cycle before chip select rises
    task automatic xfer(input logic cs_on, wr, bsel, stat, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge i_clk);
        #1;
        o_cs_n = !cs_on;
        o_bsel = bsel;
        o_ssel = stat;
        if (wr)
            o_data = wd;
        dir_rd = !wr;
        ds_on = i_rw_mode || !wr;
        wr_on = !i_rw_mode && wr;
        repeat (2) @(posedge i_clk);
        rd = i_bus;
        #1;
        ds_on = 1'b0;
        wr_on = 1'b0;
        @(posedge i_clk);
        #1;
        o_cs_n = 1'b1;
        o_data = ~o_data; // Released bus shows no stale value
        @(posedge i_clk);
        #1;
    endtask
endmodule // phb_host_bfm

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import phb_pkg::*;
;
    logic        I_REF_CLK = 1'b0, I_RESET_N = 1'b0, I_IN_READ = 1'b0, I_OUT_WRITE = 1'b0;
    logic        I_RW_LINE_MODE = 1'b0, I_STROBE_ACTIVE_HIGH = 1'b0, I_FULL_OR_EMPTY = 1'b0;
    logic        I_BYTE_SELECT_HIGH_IS_1 = 1'b1, I_WORD_MODE = 1'b1;
    logic        I_SECOND_SERIAL_SELECT = 1'b0, I_UPPER_BITIO_ENABLE = 1'b0;
    logic [15:0] I_OUT_DATA = 16'h0000, O_IN_DATA;
    logic [3:0]  I_SERIAL_OUT = 4'h5, I_SERIAL_OE = 4'h0, O_SERIAL_IN;
    logic [7:0]  I_BIT_IO_DIR = 8'h00, I_BIT_IO_MASK = 8'h00, I_BIT_IO_PATTERN = 8'h00;
    logic [7:0]  I_BIT_IO_LINES = 8'h00, O_BIT_IO_LINES, O_BIT_IO_LINES_OE;
    logic [1:0]  I_BIT_IO_OP = PHB_BIO_HOLD;
    logic [7:0]  O_HOST_DATA_BUS, O_HOST_DATA_BUS_OE;
    logic        O_HOST_IN_FULL_FLAG, O_HOST_OUT_EMPTY_FLAG, O_IN_VALID, O_OUT_READY;
    logic        O_BIT_IO_MATCH, O_BIT_IO_ANY;
    wire         I_HOST_CHIP_SELECT_N, I_HOST_BYTE_SELECT, I_HOST_STATUS_SELECT;
    wire         I_HOST_INPUT_STROBE, I_HOST_OUTPUT_STROBE;
    wire  [7:0]  I_HOST_DATA_BUS, hdrv;
    int          err_total = 0, n_compared = 0;

    // Clock and resolved host bus
    always #50 I_REF_CLK = ~I_REF_CLK;
    assign I_HOST_DATA_BUS = (O_HOST_DATA_BUS & O_HOST_DATA_BUS_OE) | (hdrv & ~O_HOST_DATA_BUS_OE);

    phb_host_port dut_u (.*);
    phb_host_bfm host_u (.i_clk(I_REF_CLK), .i_rw_mode(I_RW_LINE_MODE),
        .i_act_high(I_STROBE_ACTIVE_HIGH), .i_bus(I_HOST_DATA_BUS),
        .o_cs_n(I_HOST_CHIP_SELECT_N), .o_bsel(I_HOST_BYTE_SELECT),
        .o_ssel(I_HOST_STATUS_SELECT), .o_istb(I_HOST_INPUT_STROBE),
        .o_ostb(I_HOST_OUTPUT_STROBE), .o_data(hdrv));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge I_REF_CLK);
        #1;
    endtask
    task automatic hw(input logic [15:0] w);
        logic [7:0] d;
        host_u.xfer(1'b1, 1'b1, 1'b1, 1'b0, w[15:8], d);
        host_u.xfer(1'b1, 1'b1, 1'b0, 1'b0, w[7:0], d);
    endtask
    task automatic hr(input logic [15:0] w);
        logic [7:0] d;
        host_u.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, d);
        chk(d, w[15:8]);
        host_u.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, d);
        chk(d, w[7:0]);
    endtask
    task automatic pw(input logic [15:0] w);
        I_OUT_DATA = w;
        I_OUT_WRITE = 1'b1;
        cyc(1);
        I_OUT_WRITE = 1'b0;
        cyc(2);
    endtask
    task automatic pop;
        I_IN_READ = 1'b1;
        cyc(1);
        I_IN_READ = 1'b0;
        cyc(3);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] d;
        chk(O_HOST_IN_FULL_FLAG, 16'h0000);
        chk(O_HOST_OUT_EMPTY_FLAG, 16'h0001);
        host_u.xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'h00, d);
        chk(d, 16'h0002);
        hw(16'h0000);
        host_u.xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h77, d);
        host_u.xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h77, d);
        cyc(4);
        chk(O_IN_VALID, 16'h0001);
        pop;
        chk(O_IN_VALID, 16'h0000);
        $display("test reset_select done");
    endtask
    task automatic t_fill;
        logic [7:0] d;
        int n;
        for (int k = 0; k < 18; k++)
            hw({k[7:0], ~k[7:0]});
        chk(O_HOST_IN_FULL_FLAG, 16'h0001);
        host_u.xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'h00, d);
        chk(d, 16'h0003);
        n = 0;
        while (O_IN_VALID === 1'b1 && n < 20) begin
            chk(O_IN_DATA, {n[7:0], ~n[7:0]});
            pop;
            n++;
        end
        chk(16'(n >= 16 && n <= 17), 16'h0001);
        chk(O_HOST_IN_FULL_FLAG, 16'h0000);
        $display("test fill_drain done");
    endtask
    task automatic t_read;
        I_FULL_OR_EMPTY = 1'b1;
        cyc(3);
        chk(O_HOST_IN_FULL_FLAG, 16'h0001);
        pw(16'h5AC3);
        pw(16'h0000);
        cyc(2);
        chk({O_OUT_READY, O_HOST_OUT_EMPTY_FLAG, O_HOST_IN_FULL_FLAG}, 16'h0000);
        hr(16'h5AC3);
        cyc(3);
        chk(O_HOST_OUT_EMPTY_FLAG, 16'h0001);
        I_FULL_OR_EMPTY = 1'b0;
        $display("test host_read done");
    endtask
    task automatic t_rw;
        I_RW_LINE_MODE = 1'b1;
        for (int a = 0; a < 2; a++) begin
            I_STROBE_ACTIVE_HIGH = a[0];
            cyc(2);
            hw(16'hC0DE ^ a[15:0]);
            cyc(3);
            chk(O_IN_DATA, 16'hC0DE ^ a[15:0]);
            pop;
            pw(16'h1234 + a[15:0]);
            hr(16'h1234 + a[15:0]);
        end
        I_RW_LINE_MODE = 1'b0;
        $display("test rw_line done");
    endtask
    task automatic t_bitio;
        logic [1:0] op[4] = '{PHB_BIO_SET, PHB_BIO_TOGGLE, PHB_BIO_CLEAR, PHB_BIO_CLEAR};
        logic [7:0] m[4] = '{8'hFF, 8'h0F, 8'h30, 8'hFF};
        logic [7:0] e[4] = '{8'hFF, 8'hF0, 8'hC0, 8'h00};
        logic [7:0] p[3] = '{8'h05, 8'h06, 8'h0A};
        logic [1:0] r[3] = '{2'h3, 2'h1, 2'h0};
        I_SECOND_SERIAL_SELECT = 1'b1;
        I_UPPER_BITIO_ENABLE = 1'b1;
        I_SERIAL_OE = 4'hF;
        cyc(3);
        chk({O_HOST_DATA_BUS_OE[3:0], O_HOST_DATA_BUS[3:0], O_SERIAL_IN}, 16'h0F55);
        I_SERIAL_OE = 4'h0;
        I_BIT_IO_DIR = 8'hFF;
        for (int i = 0; i < 4; i++) begin
            I_BIT_IO_OP = op[i];
            I_BIT_IO_MASK = m[i];
            cyc(1);
            I_BIT_IO_OP = PHB_BIO_HOLD;
            cyc(2);
            chk(O_BIT_IO_LINES, e[i]);
        end
        I_BIT_IO_DIR = 8'hF0;
        I_BIT_IO_LINES = 8'hA5;
        I_BIT_IO_MASK = 8'h0F;
        for (int i = 0; i < 3; i++) begin
            I_BIT_IO_PATTERN = p[i];
            cyc(3);
            chk({O_BIT_IO_LINES_OE, 6'h00, O_BIT_IO_MATCH, O_BIT_IO_ANY}, {8'hF0, 6'h00, r[i]});
        end
        I_SECOND_SERIAL_SELECT = 1'b0;
        $display("test bit_io done");
    endtask

    task automatic t_byte;
        logic [7:0] d;
        I_WORD_MODE = 1'b0;
        host_u.xfer(1'b1, 1'b1, 1'b1, 1'b0, 8'h3C, d);
        cyc(3);
        chk(O_IN_DATA, 16'h003C);
        pop;
        pw(16'hA55A);
        host_u.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, d);
        chk(d, 16'h005A);
        I_WORD_MODE = 1'b1;
        I_BYTE_SELECT_HIGH_IS_1 = 1'b0;
        pw(16'h6699);
        host_u.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, d);
        chk(d, 16'h0066);
        host_u.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, d);
        chk(d, 16'h0099);
        cyc(2);
        chk(O_HOST_OUT_EMPTY_FLAG, 16'h0001);
        I_BYTE_SELECT_HIGH_IS_1 = 1'b1;
        $display("test byte_mode done");
    endtask

    // Closing report and verdict
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge I_REF_CLK);
        #1;
        I_RESET_N = 1'b1;
        cyc(1);
        t_reset;
        t_fill;
        t_read;
        t_rw;
        t_byte;
        t_bitio;
        tally_and_finish;
    end

    // Watchdog well beyond the expected run
    initial begin
        #2_000_000;
        err_total++;
        tally_and_finish;
    end
endmodule // tb_top
